// ==== src/lsf_top.sv ====
// Status flags of a combined UART / LIN serial controller, Wishbone slave
// Assumes the framing datapath and baud generator deliver same-clock pulses
//
// Functional notes
// - Received byte sets data available; read clears
// - Parity failure sets flag; data read clears
// - Unread byte overwritten sets overrun; read clears
// - Missing stop bit sets framing flag
// - UART all-zero character sets break flag
// - Holding empty until software writes transmit data
// - Idle only when shifter empty, character sent
// - Lowest bit: clear-to-send or autobaud done
// - Autobaud counter overflow sets overrun and done
// - Sleep: four low bit times set break
// - Wait for break: eleven bit times
// - Active: ten low bit times set break
// - LIN: status or data read clears break
// - Autobaud character sets done, optional interrupt
// - Status read clears done; zero in master
// - Status bits read only; lowest depends on mode
// - Slave hardware walks the bus phase field
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
`include "lsf_map.svh"
module lsf_top
  import lsf_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Pins
  input  wire logic        lin_rxd,
  input  wire logic        cts_n,
  // Receive datapath events
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_parity_bad,
  input  wire logic        rx_stop_bad,
  input  wire logic        rx_all_zero,
  // Transmit datapath
  input  wire logic        tx_take,
  input  wire logic        tx_shift_busy,
  output logic             tx_hold_full,
  output logic      [7:0]  tx_hold_byte,
  // Baud generator and autobaud
  input  wire logic        bit_tick,
  input  wire logic        brg_overflow,
  input  wire logic        autobaud_char_done,
  // Mode and events out
  output lsf_phase_t       bus_phase_state,
  output logic             rx_irq
);

  lsf_top_st_t s;
  lsf_top_st_t n;

  lsf_brk_if brk ();

  // Decoding shared by every register access
  function automatic logic hit_reg(input logic [15:0] adr, input logic [13:0] idx);
    hit_reg = (adr[15:2] == idx);
  endfunction

  function automatic logic [3:0] break_need(input lsf_phase_t ph, input logic slave, input logic lin);
    logic [3:0] v;
    v = `LSF_BRK_NONE;
    if (lin) begin
      case (ph)
        LSF_SLEEP: begin
          v = `LSF_BRK_SLEEP;
        end
        LSF_WAIT_BRK: begin
          v = slave ? `LSF_BRK_WAIT : `LSF_BRK_NONE;
        end
        LSF_ACTIVE: begin
          v = slave ? `LSF_BRK_ACTIVE : `LSF_BRK_NONE;
        end
        default: begin
          v = `LSF_BRK_NONE;
        end
      endcase
    end
    break_need = v;
  endfunction

  logic       acc;
  logic       rd;
  logic       wr;
  logic       rd_rx;
  logic       rd_st;
  logic       rd_ctl;
  logic       wr_tx;
  logic       wr_ctl;
  logic       lin_mode;
  logic       in_ab;
  logic       atb_set;
  logic       oe_set;
  logic       brk_set;
  logic       brk_clr;
  logic [7:0] st_byte;
  logic [7:0] ctl_byte;

  // Bus strobes; the access is taken in the cycle before ack
  assign acc    = wb_cyc_i & wb_stb_i & ~s.ack;
  assign rd     = acc & ~wb_we_i;
  assign wr     = acc & wb_we_i & wb_sel_i[0];
  assign rd_rx  = rd & hit_reg(wb_adr_i, `LSF_IDX_RXTX);
  assign rd_st  = rd & hit_reg(wb_adr_i, `LSF_IDX_STATUS);
  assign rd_ctl = rd & hit_reg(wb_adr_i, `LSF_IDX_CTL);
  assign wr_tx  = wr & hit_reg(wb_adr_i, `LSF_IDX_RXTX);
  assign wr_ctl = wr & hit_reg(wb_adr_i, `LSF_IDX_CTL);

  assign lin_mode = s.lin_master | s.lin_slave;
  assign in_ab    = s.lin_slave & (s.phase == LSF_AUTOBAUD);

  // Autobaud ends either with a character or with a counter overflow
  assign atb_set = in_ab & (autobaud_char_done | brg_overflow);

  // An unread byte being replaced is an overrun; a read in the same cycle frees it
  assign oe_set = (rx_valid & s.receive_data_available & ~rd_rx) | (in_ab & brg_overflow);

  // UART break comes from the framer, LIN break from the low-period detector
  assign brk_set = lin_mode ? brk.hit : (rx_valid & rx_all_zero);
  assign brk_clr = rd_rx | (lin_mode & rd_st);

  // Status byte; the lowest bit changes meaning with the mode
  always_comb begin
    st_byte = 8'h00;
    st_byte[`LSF_ST_RDA]  = s.receive_data_available;
    st_byte[`LSF_ST_PE]   = s.pe;
    st_byte[`LSF_ST_OE]   = s.oe;
    st_byte[`LSF_ST_FE]   = s.fe;
    st_byte[`LSF_ST_BRK]  = s.brk;
    st_byte[`LSF_ST_TX_HOLDING_EMPTY] = s.tx_holding_empty;
    st_byte[`LSF_ST_TXE]  = s.txidle;
    st_byte[`LSF_ST_LOW]  = lin_mode ? s.autobaud_done : ~s.cts_s2;
  end

  always_comb begin
    ctl_byte = 8'h00;
    ctl_byte[`LSF_CTL_MST]   = s.lin_master;
    ctl_byte[`LSF_CTL_SLV]   = s.lin_slave;
    ctl_byte[`LSF_CTL_AUTOBAUD_IRQ_ENABLE] = s.ab_ien;
    ctl_byte[`LSF_CTL_PH_HI:`LSF_CTL_PH_LO] = s.phase;
  end

  // Break detector feed
  assign brk.line_low  = ~s.rxd_s2;
  assign brk.bit_tick  = bit_tick;
  assign brk.need_bits = break_need(s.phase, s.lin_slave, lin_mode);
  assign brk.restart   = (s.phase != n.phase) | ~lin_mode;

  lsf_brk_det u_brk (
    .sys_clk (sys_clk),
    .srst    (srst),
    .brk     (brk)
  );

  always_comb begin
    n = s;

    // Pin synchronisers
    n.rxd_s1 = lin_rxd;
    n.rxd_s2 = s.rxd_s1;
    n.cts_s1 = cts_n;
    n.cts_s2 = s.cts_s1;

    // Single-cycle ack, dropped the cycle after it is given
    n.ack = acc;
    n.dat = 8'h00;
    if (rd_rx) begin
      n.dat = s.rx_data;
    end else if (rd_st) begin
      n.dat = st_byte;
    end else if (rd_ctl) begin
      n.dat = ctl_byte;
    end

    // Receive flags: set wins over the clear by a data read
    if (rd_rx) begin
      n.receive_data_available = 1'b0;
      n.pe  = 1'b0;
      n.fe  = 1'b0;
      n.oe  = 1'b0;
    end
    if (rx_valid) begin
      n.rx_data = rx_byte;
      n.receive_data_available     = 1'b1;
      n.pe      = rx_parity_bad;
      n.fe      = rx_stop_bad;
    end
    if (oe_set) begin
      n.oe = 1'b1;
    end

    // Break flag
    if (brk_clr) begin
      n.brk = 1'b0;
    end
    if (brk_set) begin
      n.brk = 1'b1;
    end

    // Autobaud done
    if (rd_st) begin
      n.autobaud_done = 1'b0;
    end
    if (atb_set) begin
      n.autobaud_done = 1'b1;
    end
    if (s.lin_master) begin
      n.autobaud_done = 1'b0;
    end

    // Holding register; a write beside a take keeps the new byte, so it stays full
    if (tx_take && !s.tx_holding_empty) begin
      n.tx_holding_empty = 1'b1;
    end
    if (wr_tx) begin
      n.tx_data = wb_dat_i[7:0];
      n.tx_holding_empty    = 1'b0;
    end

    // Idle drops as soon as the shifter takes a byte
    n.txidle = ~tx_shift_busy & ~tx_take;

    // Receive interrupt pulse
    n.rx_irq = rx_valid | (atb_set & s.ab_ien);

    // Slave phase walk
    if (s.lin_slave) begin
      case (s.phase)
        LSF_WAIT_BRK: begin
          if (brk.hit) begin
            n.phase = LSF_AUTOBAUD;
          end
        end
        LSF_AUTOBAUD: begin
          if (brg_overflow) begin
            n.phase = LSF_WAIT_BRK;
          end else if (autobaud_char_done) begin
            n.phase = LSF_ACTIVE;
          end
        end
        LSF_ACTIVE: begin
          if (brk.hit) begin
            n.phase = LSF_AUTOBAUD;
          end
        end
        default: begin
          n.phase = s.phase;
        end
      endcase
    end

    // Software control write wins over the hardware phase step
    if (wr_ctl) begin
      n.lin_master = wb_dat_i[`LSF_CTL_MST];
      n.lin_slave  = wb_dat_i[`LSF_CTL_SLV];
      n.ab_ien     = wb_dat_i[`LSF_CTL_AUTOBAUD_IRQ_ENABLE];
      n.phase      = lsf_phase_t'(wb_dat_i[`LSF_CTL_PH_HI:`LSF_CTL_PH_LO]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s        <= '0;
      s.tx_holding_empty   <= `LSF_RST_TX_HOLDING_EMPTY;
      s.txidle <= `LSF_RST_TXE;
      s.rxd_s1 <= `LSF_RST_PIN;
      s.rxd_s2 <= `LSF_RST_PIN;
      s.cts_s1 <= `LSF_RST_PIN;
      s.cts_s2 <= `LSF_RST_PIN;
    end else begin
      s <= n;
    end
  end

  // Status is never written: no strobe reaches it
  assign wb_dat_o        = {24'h000000, s.dat};
  assign wb_ack_o        = s.ack;
  assign tx_hold_full    = ~s.tx_holding_empty;
  assign tx_hold_byte    = s.tx_data;
  assign bus_phase_state = s.phase;
  assign rx_irq          = s.rx_irq;

endmodule // lsf_top

// ==== common/lsf_map.svh ====
// Register offsets, field positions, reset values and break thresholds
// Assumes 32-bit classic Wishbone with byte addresses; indices are word numbers
`ifndef LSF_MAP_SVH
`define LSF_MAP_SVH

// Register indices and byte addresses (byte address is four times the index)
`define LSF_IDX_RXTX   14'hf40
`define LSF_IDX_STATUS 14'hf41
`define LSF_IDX_CTL    14'hf43
`define LSF_ADR_RXTX   {`LSF_IDX_RXTX, 2'b00}
`define LSF_ADR_STATUS {`LSF_IDX_STATUS, 2'b00}
`define LSF_ADR_CTL    {`LSF_IDX_CTL, 2'b00}

// Status bit positions
`define LSF_ST_RDA   7
`define LSF_ST_PE    6
`define LSF_ST_OE    5
`define LSF_ST_FE    4
`define LSF_ST_BRK   3
`define LSF_ST_TX_HOLDING_EMPTY  2
`define LSF_ST_TXE   1
`define LSF_ST_LOW   0

// Control bit positions
`define LSF_CTL_MST   0
`define LSF_CTL_SLV   1
`define LSF_CTL_AUTOBAUD_IRQ_ENABLE 2
`define LSF_CTL_PH_LO 3
`define LSF_CTL_PH_HI 4

// Reset values
`define LSF_RST_TX_HOLDING_EMPTY  1'b1
`define LSF_RST_TXE   1'b1
// Both pins idle high; synchronisers leave reset at that level so no false low shows
`define LSF_RST_PIN   1'b1

// Break lengths in bit times
`define LSF_BRK_SLEEP  4'h4
`define LSF_BRK_WAIT   4'hb
`define LSF_BRK_ACTIVE 4'ha
`define LSF_BRK_NONE   4'h0
`define LSF_BRK_SAT    4'hf

`endif

// ==== common/lsf_pkg.sv ====
// Types shared by the status flag block and its break detector
// Assumes the constants of lsf_map.svh are included where needed
package lsf_pkg;

  // Gray along sleep, wait for break, autobaud, active
  typedef enum logic [1:0] {
    LSF_SLEEP    = 2'b00,
    LSF_WAIT_BRK = 2'b01,
    LSF_AUTOBAUD = 2'b11,
    LSF_ACTIVE   = 2'b10
  } lsf_phase_t;

  typedef struct packed {
    logic       rxd_s1;
    logic       rxd_s2;
    logic       cts_s1;
    logic       cts_s2;
    logic       receive_data_available;
    logic       pe;
    logic       oe;
    logic       fe;
    logic       brk;
    logic       tx_holding_empty;
    logic       txidle;
    logic       autobaud_done;
    lsf_phase_t phase;
    logic       lin_master;
    logic       lin_slave;
    logic       ab_ien;
    logic [7:0] rx_data;
    logic [7:0] tx_data;
    logic       ack;
    logic [7:0] dat;
    logic       rx_irq;
  } lsf_top_st_t;

  typedef struct packed {
    logic [3:0] low_bits;
    logic       hit;
  } lsf_brk_st_t;

endpackage

// ==== common/lsf_brk_if.sv ====
// Carrier between the status flag block and the break detector
// Assumes both ends run on the same clock
`timescale 1ns/1ps
interface lsf_brk_if;
  logic       line_low;
  logic       bit_tick;
  logic       restart;
  logic [3:0] need_bits;
  logic       hit;

  modport det (input line_low, input bit_tick, input restart, input need_bits, output hit);
  modport ctl (output line_low, output bit_tick, output restart, output need_bits, input hit);
endinterface

// ==== src/lsf_brk_det.sv ====
// Break detector: counts whole bit times of low line level
// Assumes bit_tick is a one-cycle pulse per bit time on the same clock
`timescale 1ns/1ps
`include "lsf_map.svh"
module lsf_brk_det
  import lsf_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  // Link to the flag logic
  lsf_brk_if.det    brk
);

  lsf_brk_st_t s;
  lsf_brk_st_t n;
  logic [3:0]  inc;

  assign inc = s.low_bits + 4'h1;

  always_comb begin
    n = s;
    n.hit = 1'b0;
    if (brk.restart || !brk.line_low) begin
      n.low_bits = 4'h0;
    end else if (brk.bit_tick && s.low_bits != `LSF_BRK_SAT) begin
      n.low_bits = inc;
      // One pulse per low period, at the bit that reaches the length
      if (brk.need_bits != `LSF_BRK_NONE && inc == brk.need_bits) begin
        n.hit = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign brk.hit = s.hit;

endmodule // lsf_brk_det

// ==== testbench/lsf_node_model.sv ====
// Remote LIN node: holds the line low for a break, gives the bit tick
// Assumes the line has a pull-up, so a released line reads high
`timescale 1ns/1ps
module lsf_node_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // Break request
  input  wire logic       send_break,
  input  wire logic [4:0] brk_bits,
  // Line side
  output logic            lin_rxd,
  output logic            bit_tick,
  output logic            busy
);
  logic [2:0] div_reg;
  logic [4:0] left_reg;
  assign bit_tick = (div_reg == 3'h7);
  assign busy     = (left_reg != 5'h0);
  // One tick past the length, so the last low bit is surely counted
  always @(posedge sys_clk) begin
    if (srst) begin
      div_reg  <= 3'h0;
      left_reg <= 5'h0;
      lin_rxd  <= 1'b1;
    end else begin
      div_reg <= div_reg + 3'h1;
      if (send_break) begin
        left_reg <= brk_bits + 5'h1;
        lin_rxd  <= 1'b0;
      end else if (bit_tick && busy) begin
        left_reg <= left_reg - 5'h1;
        if (left_reg == 5'h1) lin_rxd <= 1'b1;
      end
    end
  end
endmodule // lsf_node_model

// ==== testbench/lsf_top_monitor.sv ====
// Port checks of the status flag block
// Assumes one clock domain with synchronous srst
`timescale 1ns/1ps
`include "lsf_map.svh"
module lsf_top_monitor (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        srst,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Events
  input wire logic        rx_valid,
  input wire logic        tx_take,
  input wire logic        autobaud_char_done,
  input wire logic        brg_overflow,
  input wire logic        tx_hold_full,
  input wire logic [7:0]  tx_hold_byte,
  input wire logic        rx_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence wr_s;
    req_s ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == `LSF_ADR_RXTX);
  endsequence
  ack_follow_a: assert property (req_s |=> wb_ack_o) else $error("ack missing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  hold_fill_a: assert property (wr_s |=> tx_hold_full && tx_hold_byte == $past(wb_dat_i[7:0]))
    else $error("write not held");
  hold_keep_a: assert property (tx_hold_full && !tx_take |=> tx_hold_full) else $error("byte lost");
  hold_drain_a: assert property (tx_take && tx_hold_full && !wb_cyc_i |=> !tx_hold_full)
    else $error("take ignored");
  irq_rx_a: assert property (rx_valid |=> rx_irq) else $error("no receive irq");
  irq_cause_a: assert property (rx_irq |->
    $past(rx_valid) || $past(autobaud_char_done) || $past(brg_overflow)) else $error("stray irq");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
endmodule // lsf_top_monitor

bind lsf_top lsf_top_monitor u_mon (.sys_clk(sys_clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .rx_valid(rx_valid), .tx_take(tx_take), .autobaud_char_done(autobaud_char_done),
  .brg_overflow(brg_overflow),
  .tx_hold_full(tx_hold_full), .tx_hold_byte(tx_hold_byte), .rx_irq(rx_irq));

// ==== testbench/testbench.sv ====
// Self-checking bench for the status flag block
// Assumes the node model makes the line and bit tick
`timescale 1ns/1ps
`include "lsf_map.svh"
module testbench;
  import lsf_pkg::*;
  logic sys_clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, cts_n = 1, rx_valid = 0, rx_parity_bad = 0;
  logic rx_stop_bad = 0, rx_all_zero = 0, tx_take = 0, tx_shift_busy = 0, brg_overflow = 0, abd = 0;
  logic send_break = 0, lin_rxd, bit_tick, busy, ack, tx_hold_full, rx_irq;
  logic [4:0] brk_bits = 5'h0;
  logic [15:0] adr = 16'h0;
  logic [31:0] dat = 32'h0, rd, q;
  logic [7:0] rx_byte = 8'h0, tx_hold_byte;
  lsf_phase_t ph;
  int fails = 0, n_compared = 0;
  always #20 sys_clk = ~sys_clk;
  lsf_top dut (.sys_clk(sys_clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .lin_rxd(lin_rxd), .cts_n(cts_n),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_parity_bad(rx_parity_bad), .rx_stop_bad(rx_stop_bad),
    .rx_all_zero(rx_all_zero), .tx_take(tx_take), .tx_shift_busy(tx_shift_busy), .tx_hold_full(tx_hold_full),
    .tx_hold_byte(tx_hold_byte), .bit_tick(bit_tick), .brg_overflow(brg_overflow),
    .autobaud_char_done(abd), .bus_phase_state(ph), .rx_irq(rx_irq));
  lsf_node_model node (.sys_clk(sys_clk), .srst(srst), .send_break(send_break), .brk_bits(brk_bits),
    .lin_rxd(lin_rxd), .bit_tick(bit_tick), .busy(busy));
  task automatic give_verdict;
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Classic cycle: hold until ack is sampled, then release for a cycle
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge sys_clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    do begin @(posedge sys_clk); n++; end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      fails++;
      give_verdict;
    end
    q = rd;
    cyc <= 0; stb <= 0;
  endtask
  task automatic st(input logic [7:0] e);
    wb(0, `LSF_ADR_STATUS, 0);
    chk(q, {24'h0, e});
  endtask
  task automatic ev(input logic [7:0] b, input logic p, input logic f, input logic z);
    @(posedge sys_clk);
    rx_valid <= 1; rx_byte <= b; rx_parity_bad <= p; rx_stop_bad <= f; rx_all_zero <= z;
    @(posedge sys_clk);
    rx_valid <= 0;
  endtask
  task automatic brk(input logic [4:0] n);
    @(posedge sys_clk);
    send_break <= 1; brk_bits <= n;
    @(posedge sys_clk);
    send_break <= 0;
    @(posedge sys_clk);
    while (busy) @(posedge sys_clk);
    repeat (6) @(posedge sys_clk);
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    give_verdict;
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    srst <= 0;
    st(8'h06);
    cts_n <= 0;
    repeat (4) @(posedge sys_clk);
    st(8'h07);
    wb(0, 16'h3d08, 0); chk(q, 0);
    wb(1, `LSF_ADR_STATUS, 32'hff); st(8'h07);
    ev(8'ha5, 0, 0, 0); ev(8'h3c, 1, 1, 0); st(8'hf7);
    wb(0, `LSF_ADR_RXTX, 0); chk(q, 32'h3c); st(8'h07);
    ev(8'h00, 0, 1, 1); st(8'h9f); st(8'h9f);
    wb(0, `LSF_ADR_RXTX, 0); st(8'h07);
    wb(1, `LSF_ADR_RXTX, 32'h5a);
    st(8'h03); chk(tx_hold_byte, 8'h5a);
    tx_take <= 1; tx_shift_busy <= 1;
    @(posedge sys_clk);
    tx_take <= 0;
    st(8'h05);
    tx_shift_busy <= 0; st(8'h07);
    wb(1, `LSF_ADR_CTL, 32'h02); brk(5'h4); st(8'h0e); st(8'h06);
    wb(1, `LSF_ADR_CTL, 32'h0e); brk(5'hb); st(8'h0e); chk(ph, LSF_AUTOBAUD);
    abd <= 1;
    @(posedge sys_clk);
    abd <= 0;
    #1 chk(rx_irq, 1);
    st(8'h07); chk(ph, LSF_ACTIVE); st(8'h06);
    brk(5'ha); st(8'h0e); chk(ph, LSF_AUTOBAUD);
    brg_overflow <= 1;
    @(posedge sys_clk);
    brg_overflow <= 0;
    st(8'h27); chk(ph, LSF_WAIT_BRK);
    wb(0, `LSF_ADR_RXTX, 0); st(8'h06);
    // Break left standing, then cleared by a data read; done flag left set, then master mode
    brk(5'hb); wb(0, `LSF_ADR_RXTX, 0);
    abd <= 1;
    @(posedge sys_clk);
    abd <= 0;
    wb(1, `LSF_ADR_CTL, 32'h01); st(8'h06);
    give_verdict;
  end
endmodule // testbench
